// ---- rtl/ea_defs.svh ----
// constants for the effective address unit: field positions, codes, steps
`ifndef EA_DEFS_SVH
`define EA_DEFS_SVH
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_DISP 3'h5
`define MODE_INDEX 3'h6
`define MODE_SPECIAL 3'h7
`define SUB_PC_DISP 3'h2
`define SUB_PC_INDEX 3'h3
`define SUB_IMM 3'h4
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define XB_DA 15
`define XB_NUM_HI 14
`define XB_NUM_LO 12
`define XB_WL 11
`define XB_SCL_HI 10
`define XB_SCL_LO 9
`define XB_FULL 8
`define XB_BS 7
`define XB_IS 6
`define XB_BD_HI 5
`define XB_BD_LO 4
`define XB_IIS_HI 2
`define BD_RSVD 2'h0
`define BD_WORD 2'h2
`define BD_LONG 2'h3
`define SP_NUM 3'h7
`define RF_AREG_BASE 5'h08
`define RF_USP 5'h0F
`define RF_SSP 5'h10
`define RF_DEPTH 17
`define STEP_ONE 32'h00000001
`define STEP_TWO 32'h00000002
`define STEP_FOUR 32'h00000004
`endif

// ---- rtl/ea_pkg.sv ----
// types shared by the effective address unit and its users
package ea_pkg;
    typedef enum logic [1:0] {LOC_NONE, LOC_DREG, LOC_AREG, LOC_MEM} loc_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_CALC, ST_POST} ea_state_t;
endpackage

// ---- rtl/effective_address_unit.sv ----
// effective address decoder with its own data/address register file
//
// Function
// - split the six-bit specifier into a 3-bit mode and a 3-bit register.
// - fetches of opcode and extension words are tagged program space.
// - operand reads are data space, except immediate, pc-relative and indexed jump reads.
// - every operand write goes to data space.
// - data register direct names a data register, no memory access.
// - address register direct names an address register, no memory access.
// - register indirect uses the address register, leaving it unchanged.
// - postincrement uses the register, then adds 1, 2 or 4 after access.
// - byte postincrement of the stack pointer adds two.
// - predecrement subtracts 1, 2 or 4 first, then uses the new value.
// - byte predecrement of the stack pointer subtracts two.
// - displacement mode adds the sign-extended 16-bit extension word.
// - every displacement is sign-extended to 32 bits before adding.
// - brief index: register plus sign-extended low byte plus scaled index.
// - brief and full extension formats, full with 16 or 32-bit displacement.
// - brief indexed references are data space except for jumps.
// - extension bit 15 picks data (0) or address (1) index register.
// - extension bits 14 to 12 give the index register number.
// - bit 11 picks sign-extended low word (0) or full register (1).
// - bits 10 to 9 scale the index by 1, 2, 4 or 8.
// - address register 7 is user or supervisor stack by privilege.
`timescale 1ns/1ns
`include "ea_defs.svh"

module effective_address_unit
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ea_req,
    input wire logic [5:0] ea_field,
    input wire logic [1:0] op_size,
    input wire logic op_write,
    input wire logic op_jump,
    input wire logic supervisor,
    input wire logic op_fetch_req,
    input wire logic fetch_ack,
    input wire logic [15:0] fetch_word,
    input wire logic acc_done,
    input wire logic wr_en,
    input wire logic wr_addr_reg,
    input wire logic [2:0] wr_num,
    input wire logic [1:0] wr_size,
    input wire logic [31:0] wr_data,
    input wire logic rd_addr_reg,
    input wire logic [2:0] rd_num,
    output logic fetch_req_ff,
    output logic fetch_prog_ff,
    output logic done_ff,
    output logic bad_ff,
    output ea_pkg::loc_kind_t loc_kind_ff,
    output logic [2:0] loc_num_ff,
    output logic [31:0] operand_locator_ff,
    output logic loc_prog_ff,
    output logic busy_ff,
    output logic [31:0] rd_data_ff
);
    import ea_pkg::*;

    // ****************************************
    // decode helpers
    // ****************************************

    // d0-d7, a0-a6, then both stack pointers
    function automatic logic [4:0] phys(input logic is_a, input logic [2:0] n,
                                        input logic sup);
        logic [4:0] idx;
        idx = {2'h0, n};
        if (is_a)
        begin
            if (n == `SP_NUM)
                idx = sup ? `RF_SSP : `RF_USP;
            else
                idx = `RF_AREG_BASE + {2'h0, n};
        end
        return idx;
    endfunction

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    // ****************************************
    // state
    // ****************************************

    logic [31:0] regs [0:`RF_DEPTH-1];
    ea_state_t state_ff;
    ea_state_t nxt_state;
    logic [2:0] mode_ff;
    logic [2:0] num_ff;
    logic [1:0] size_ff;
    logic write_ff;
    logic jump_ff;
    logic sup_ff;
    logic [15:0] ext_ff;
    logic [31:0] bd_ff;
    logic [1:0] left_ff;
    logic first_ff;

    // ****************************************
    // address arithmetic
    // ****************************************

    wire [4:0] base_idx = phys(1'b1, num_ff, sup_ff);
    wire [31:0] base = regs[base_idx];
    wire sp_base = (num_ff == `SP_NUM);
    wire [31:0] step = (size_ff == `SZ_BYTE) ? (sp_base ? `STEP_TWO : `STEP_ONE)
                     : (size_ff == `SZ_WORD) ? `STEP_TWO : `STEP_FOUR;

    wire [4:0] x_idx = phys(ext_ff[`XB_DA], ext_ff[`XB_NUM_HI:`XB_NUM_LO], sup_ff);
    wire [31:0] x_raw = regs[x_idx];
    wire [31:0] x_val = ext_ff[`XB_WL] ? x_raw : sext16(x_raw[15:0]);
    wire [31:0] x_scaled = x_val << ext_ff[`XB_SCL_HI:`XB_SCL_LO];
    wire [31:0] d8 = {{24{ext_ff[7]}}, ext_ff[7:0]};

    wire is_full = ext_ff[`XB_FULL];
    wire [1:0] bd_size = ext_ff[`XB_BD_HI:`XB_BD_LO];
    wire [31:0] bd_val = (bd_size == `BD_WORD) ? sext16(bd_ff[15:0]) : bd_ff;
    wire [31:0] full_base = ext_ff[`XB_BS] ? 32'h00000000 : base;
    wire [31:0] full_idx = ext_ff[`XB_IS] ? 32'h00000000 : x_scaled;
    // memory indirect forms are not handled; they are flagged instead
    wire full_bad = (ext_ff[`XB_IIS_HI:0] != 3'h0) || (bd_size == `BD_RSVD);

    // all sums stay 32 bits wide so carries out of bit 31 drop
    wire [31:0] brief_addr = base + d8 + x_scaled;
    wire [31:0] full_addr = full_base + full_idx + bd_val;
    wire [31:0] disp_addr = base + sext16(ext_ff);
    wire [31:0] dec_addr = base - step;
    wire [31:0] inc_addr = base + step;

    logic [31:0] calc_addr;
    always_comb
    begin
        case (mode_ff)
            `MODE_IND: calc_addr = base;
            `MODE_POSTINC: calc_addr = base;
            `MODE_PREDEC: calc_addr = dec_addr;
            `MODE_DISP: calc_addr = disp_addr;
            `MODE_INDEX: calc_addr = is_full ? full_addr : brief_addr;
            default: calc_addr = 32'h00000000;
        endcase
    end

    // ****************************************
    // classification
    // ****************************************

    wire pc_rel = (mode_ff == `MODE_SPECIAL) &&
                  (num_ff == `SUB_PC_DISP || num_ff == `SUB_PC_INDEX || num_ff == `SUB_IMM);
    wire jump_idx = (mode_ff == `MODE_INDEX) && jump_ff;
    wire calc_prog = !write_ff && (pc_rel || jump_idx);

    // pc-relative, absolute and immediate forms belong to the sequencer
    wire calc_bad = (mode_ff == `MODE_SPECIAL) ||
                    ((mode_ff == `MODE_INDEX) && is_full && full_bad) ||
                    ((mode_ff == `MODE_AREG) && (size_ff == `SZ_BYTE));

    loc_kind_t calc_kind;
    always_comb
    begin
        case (mode_ff)
            `MODE_DREG: calc_kind = LOC_DREG;
            `MODE_AREG: calc_kind = LOC_AREG;
            `MODE_SPECIAL: calc_kind = LOC_NONE;
            default: calc_kind = LOC_MEM;
        endcase
    end

    // ****************************************
    // extension word sequencing
    // ****************************************

    wire [2:0] req_mode = ea_field[5:3];
    wire [2:0] req_num = ea_field[2:0];
    wire req_ext = (req_mode == `MODE_DISP) || (req_mode == `MODE_INDEX);
    wire [1:0] word_bd = fetch_word[`XB_BD_HI:`XB_BD_LO];
    wire more_words = (mode_ff == `MODE_INDEX) && fetch_word[`XB_FULL] &&
                      (word_bd == `BD_WORD || word_bd == `BD_LONG);
    wire [1:0] first_left = (word_bd == `BD_LONG) ? 2'h2 : 2'h1;
    wire last_word = first_ff ? !more_words : (left_ff == 2'h1);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (ea_req)
                    nxt_state = req_ext ? ST_FETCH : ST_CALC;
            ST_FETCH:
                if (fetch_ack && last_word)
                    nxt_state = ST_CALC;
            ST_CALC:
                if (mode_ff == `MODE_POSTINC && !calc_bad)
                    nxt_state = ST_POST;
                else
                    nxt_state = ST_IDLE;
            ST_POST:
                if (acc_done)
                    nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    wire issue_first = (state_ff == ST_IDLE) && ea_req && req_ext;
    wire issue_more = (state_ff == ST_FETCH) && fetch_ack && !last_word;
    wire issue_op = (state_ff == ST_IDLE) && !ea_req && op_fetch_req;
    wire nxt_fetch = issue_first || issue_more || issue_op;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            fetch_req_ff <= 1'b0;
            fetch_prog_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            fetch_req_ff <= nxt_fetch;
            fetch_prog_ff <= nxt_fetch;
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ff <= 3'h0;
            num_ff <= 3'h0;
            size_ff <= 2'h0;
            write_ff <= 1'b0;
            jump_ff <= 1'b0;
            sup_ff <= 1'b0;
        end
        else if (state_ff == ST_IDLE && ea_req)
        begin
            mode_ff <= req_mode;
            num_ff <= req_num;
            size_ff <= op_size;
            write_ff <= op_write;
            jump_ff <= op_jump;
            sup_ff <= supervisor;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_ff <= 16'h0000;
            bd_ff <= 32'h00000000;
            left_ff <= 2'h0;
            first_ff <= 1'b0;
        end
        else if (issue_first)
        begin
            bd_ff <= 32'h00000000;
            first_ff <= 1'b1;
        end
        else if (state_ff == ST_FETCH && fetch_ack)
        begin
            first_ff <= 1'b0;
            if (first_ff)
            begin
                ext_ff <= fetch_word;
                left_ff <= first_left;
            end
            else
            begin
                // high word arrives first for a long displacement
                bd_ff <= {bd_ff[15:0], fetch_word};
                left_ff <= left_ff - 2'h1;
            end
        end
    end

    // ****************************************
    // results
    // ****************************************

    wire in_calc = (state_ff == ST_CALC);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_ff <= 1'b0;
            bad_ff <= 1'b0;
            loc_kind_ff <= LOC_NONE;
            loc_num_ff <= 3'h0;
            operand_locator_ff <= 32'h00000000;
            loc_prog_ff <= 1'b0;
        end
        else
        begin
            done_ff <= in_calc;
            if (in_calc)
            begin
                bad_ff <= calc_bad;
                loc_kind_ff <= calc_kind;
                loc_num_ff <= num_ff;
                operand_locator_ff <= calc_addr;
                loc_prog_ff <= calc_prog;
            end
        end
    end

    // ****************************************
    // register file
    // ****************************************

    wire upd_pre = in_calc && (mode_ff == `MODE_PREDEC) && !calc_bad;
    wire upd_post = (state_ff == ST_POST) && acc_done;
    wire upd_en = upd_pre || upd_post;
    wire [31:0] upd_val = upd_pre ? dec_addr : inc_addr;

    // sequencer writes only land while idle, so they never race an update
    wire host_wr = wr_en && (state_ff == ST_IDLE);
    wire [4:0] host_idx = phys(wr_addr_reg, wr_num, supervisor);
    wire [31:0] host_old = regs[host_idx];
    logic [31:0] host_val;
    always_comb
    begin
        if (wr_addr_reg)
            host_val = (wr_size == `SZ_WORD) ? sext16(wr_data[15:0]) : wr_data;
        else if (wr_size == `SZ_BYTE)
            host_val = {host_old[31:8], wr_data[7:0]};
        else if (wr_size == `SZ_WORD)
            host_val = {host_old[31:16], wr_data[15:0]};
        else
            host_val = wr_data;
    end

    wire [4:0] rf_widx = upd_en ? base_idx : host_idx;
    wire rf_we = upd_en || host_wr;
    wire [31:0] rf_wval = upd_en ? upd_val : host_val;

    genvar gi;
    generate
        for (gi = 0; gi < `RF_DEPTH; gi++)
        begin : g_rf
            always_ff @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                    regs[gi] <= 32'h00000000;
                else if (rf_we && rf_widx == 5'(gi))
                    regs[gi] <= rf_wval;
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rd_data_ff <= 32'h00000000;
        else
            rd_data_ff <= regs[phys(rd_addr_reg, rd_num, supervisor)];
    end

endmodule // effective_address_unit

// ---- dv/ea_unit_chk.sv ----
// port assertions for the effective address unit
`timescale 1ns/1ns
module ea_unit_chk
    import ea_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ea_req,
    input wire logic [5:0] ea_field,
    input wire logic [1:0] op_size,
    input wire logic op_write,
    input wire logic op_jump,
    input wire logic fetch_req_ff,
    input wire logic fetch_prog_ff,
    input wire logic done_ff,
    input wire logic bad_ff,
    input wire ea_pkg::loc_kind_t loc_kind_ff,
    input wire logic [2:0] loc_num_ff,
    input wire logic [31:0] operand_locator_ff,
    input wire logic loc_prog_ff,
    input wire logic busy_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [2:0] mode_ff;
    logic w_ff;
    logic j_ff;
    wire take = ea_req && !busy_ff;
    wire [2:0] md = ea_field[5:3];
    // decode attributes held from the take edge to the answer
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            {mode_ff, w_ff, j_ff} <= 5'h00;
        else if (take)
            {mode_ff, w_ff, j_ff} <= {md, op_write, op_jump};
    end
    property p_take_busy; take |=> busy_ff; endproperty
    a_take_busy: assert property (p_take_busy) else $error("decode not started");
    property p_fetch_prog; fetch_req_ff |-> fetch_prog_ff; endproperty
    a_fetch_prog: assert property (p_fetch_prog) else $error("fetch not program");
    property p_read_space; done_ff && !w_ff && mode_ff inside {[3'h2:3'h5]} |-> !loc_prog_ff;
    endproperty
    a_read_space: assert property (p_read_space) else $error("read not data");
    property p_write_space; done_ff && w_ff |-> !loc_prog_ff; endproperty
    a_write_space: assert property (p_write_space) else $error("write not data");
    property p_dreg;
        take && md == 3'h0 |-> ##2 done_ff && loc_kind_ff == LOC_DREG
            && loc_num_ff == $past(ea_field[2:0], 2) && operand_locator_ff == 32'h0;
    endproperty
    a_dreg: assert property (p_dreg) else $error("data reg direct wrong");
    property p_areg;
        take && md == 3'h1 && op_size != 2'h0 |-> ##2 done_ff && loc_kind_ff == LOC_AREG
            && loc_num_ff == $past(ea_field[2:0], 2);
    endproperty
    a_areg: assert property (p_areg) else $error("addr reg direct wrong");
    property p_ind; take && md == 3'h2 |-> ##2 done_ff && loc_kind_ff == LOC_MEM; endproperty
    a_ind: assert property (p_ind) else $error("indirect wrong");
    property p_ext_fetch; take && (md == 3'h5 || md == 3'h6) |=> fetch_req_ff && !done_ff;
    endproperty
    a_ext_fetch: assert property (p_ext_fetch) else $error("no extension fetch");
    property p_ext_done; take && md == 3'h6 |-> ##[3:40] done_ff; endproperty
    a_ext_done: assert property (p_ext_done) else $error("indexed decode hung");
    property p_idx_space; done_ff && mode_ff == 3'h6 && !bad_ff |-> loc_prog_ff == (j_ff && !w_ff);
    endproperty
    a_idx_space: assert property (p_idx_space) else $error("indexed space wrong");
    c_mem: cover property (done_ff && loc_kind_ff == LOC_MEM);
    c_prog: cover property (done_ff && loc_prog_ff);
    c_bad: cover property (done_ff && bad_ff);
endmodule // ea_unit_chk
bind effective_address_unit ea_unit_chk chk_u (.mclk(mclk), .rstn(rstn), .ea_req(ea_req),
    .ea_field(ea_field), .op_size(op_size), .op_write(op_write), .op_jump(op_jump),
    .fetch_req_ff(fetch_req_ff), .fetch_prog_ff(fetch_prog_ff), .done_ff(done_ff),
    .bad_ff(bad_ff), .loc_kind_ff(loc_kind_ff), .loc_num_ff(loc_num_ff),
    .operand_locator_ff(operand_locator_ff), .loc_prog_ff(loc_prog_ff), .busy_ff(busy_ff));

// ---- dv/ea_partner.sv ----
// behavioural sequencer and operand bus model facing the unit
`timescale 1ns/1ns
module ea_partner
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic fetch_req_ff,
    input wire logic busy_ff,
    input wire logic done_ff,
    input wire logic [47:0] ext_words,
    output logic fetch_ack = 1'b0,
    output logic [15:0] fetch_word = 16'h5A5A,
    output logic acc_done = 1'b0
);
    // requests and services are counted apart so each counter has one writer
    int reqs = 0;
    int served = 0;
    int k = 0;
    logic [15:0] last = 16'hA5A5;
    always @(posedge mclk)
        if (rstn && fetch_req_ff === 1'b1)
            reqs++;
    // words leave high first; a released data line shows the inverse of its last word
    always
    begin
        @(posedge mclk);
        #1;
        fetch_word = ~last;
        if (busy_ff !== 1'b1)
            k = 0;
        if (reqs > served)
        begin
            served++;
            repeat ($urandom_range(3)) @(posedge mclk);
            #1;
            last = ext_words[47 - 16 * k -: 16];
            fetch_word = last;
            fetch_ack = 1'b1;
            k++;
            @(posedge mclk);
            #1;
            fetch_ack = 1'b0;
            fetch_word = ~last;
        end
        else if (done_ff === 1'b1 && busy_ff === 1'b1)
        begin
            repeat ($urandom_range(3)) @(posedge mclk);
            #1;
            acc_done = 1'b1;
            @(posedge mclk);
            #1;
            acc_done = 1'b0;
        end
    end
endmodule // ea_partner

// ---- dv/tb_top.sv ----
// self-checking bench for the effective address unit
`timescale 1ns/1ns
`include "ea_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    import ea_pkg::*;
    typedef struct {logic bad; loc_kind_t kind; logic [2:0] num; logic [31:0] loc; logic prog;} note_t;
    logic mclk = 0, rstn = 0, ea_req = 0, op_write = 0, op_jump = 0, supervisor = 0, j;
    logic op_fetch_req = 0, wr_en = 0, wr_addr_reg = 0, rd_addr_reg = 0;
    logic [5:0] ea_field = 6'h00;
    logic [1:0] op_size = 2'h0, wr_size = 2'h2;
    logic [2:0] wr_num = 3'h0, rd_num = 3'h0;
    logic [31:0] wr_data = 32'h0, rd_data_ff, operand_locator_ff;
    logic [47:0] ext_words = 48'h0;
    logic [63:0] rv;
    logic fetch_ack, acc_done, fetch_req_ff, fetch_prog_ff, done_ff, bad_ff, loc_prog_ff, busy_ff;
    logic [15:0] fetch_word;
    loc_kind_t loc_kind_ff;
    logic [2:0] loc_num_ff;
    logic [31:0] dm [0:7];
    logic [31:0] am [0:8];
    note_t notes [$];
    note_t cur;
    int mismatches = 0, comparisons = 0, m, z, r;
    always #5 mclk = ~mclk;
    effective_address_unit dut_u (.mclk(mclk), .rstn(rstn), .ea_req(ea_req), .ea_field(ea_field),
        .op_size(op_size), .op_write(op_write), .op_jump(op_jump), .supervisor(supervisor),
        .op_fetch_req(op_fetch_req), .fetch_ack(fetch_ack), .fetch_word(fetch_word),
        .acc_done(acc_done), .wr_en(wr_en), .wr_addr_reg(wr_addr_reg), .wr_num(wr_num),
        .wr_size(wr_size), .wr_data(wr_data), .rd_addr_reg(rd_addr_reg), .rd_num(rd_num),
        .fetch_req_ff(fetch_req_ff), .fetch_prog_ff(fetch_prog_ff), .done_ff(done_ff),
        .bad_ff(bad_ff), .loc_kind_ff(loc_kind_ff), .loc_num_ff(loc_num_ff),
        .operand_locator_ff(operand_locator_ff), .loc_prog_ff(loc_prog_ff), .busy_ff(busy_ff),
        .rd_data_ff(rd_data_ff));
    ea_partner ptr_u (.mclk(mclk), .rstn(rstn), .fetch_req_ff(fetch_req_ff), .busy_ff(busy_ff),
        .done_ff(done_ff), .ext_words(ext_words), .fetch_ack(fetch_ack),
        .fetch_word(fetch_word), .acc_done(acc_done));
    function automatic int ai(input logic [2:0] n);
        return (n == `SP_NUM && supervisor) ? 8 : int'(n);
    endfunction
    task automatic report_and_stop();
        // a decode that never answered leaves its note behind
        if (notes.size() != 0)
            mismatches++;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rd_chk(input logic a, input logic [2:0] n);
        rd_addr_reg = a;
        rd_num = n;
        @(posedge mclk) #1;
        `CHK(rd_data_ff, a ? am[ai(n)] : dm[n])
    endtask
    task automatic wreg(input logic a, input logic [2:0] n, input logic [31:0] v);
        {wr_addr_reg, wr_num, wr_data, wr_en} = {a, n, v, 1'b1};
        if (a)
            am[ai(n)] = wr_size == `SZ_WORD ? {{16{v[15]}}, v[15:0]} : v;
        else
            dm[n] = wr_size == `SZ_BYTE ? {dm[n][31:8], v[7:0]}
                : wr_size == `SZ_WORD ? {dm[n][31:16], v[15:0]} : v;
        @(posedge mclk) #1;
        wr_en = 1'b0;
        // idle edge: back-to-back writes never reassign wr_en in one step
        @(posedge mclk) #1;
    endtask
    task automatic decode(input logic [5:0] f, input logic [1:0] sz, input logic w, input logic jp,
        input logic [47:0] ext);
        note_t e;
        logic [31:0] base, idx, dsp, st;
        int k;
        k = ai(f[2:0]);
        base = am[k];
        st = sz == `SZ_LONG ? `STEP_FOUR : sz == `SZ_WORD || f[2:0] == `SP_NUM ? `STEP_TWO
            : `STEP_ONE;
        e = '{1'b0, LOC_MEM, f[2:0], 32'h0, 1'b0};
        case (f[5:3])
            `MODE_DREG: e.kind = LOC_DREG;
            `MODE_AREG: e.kind = LOC_AREG;
            `MODE_IND, `MODE_POSTINC: e.loc = base;
            `MODE_PREDEC: e.loc = base - st;
            `MODE_DISP: e.loc = base + {{16{ext[47]}}, ext[47:32]};
            `MODE_INDEX:
            begin
                idx = ext[47] ? am[ai(ext[46:44])] : dm[ext[46:44]];
                if (!ext[43])
                    idx = {{16{idx[15]}}, idx[15:0]};
                dsp = {{24{ext[39]}}, ext[39:32]};
                if (ext[40])
                    dsp = ext[37:36] == `BD_LONG ? ext[31:0] : ext[37:36] == `BD_WORD
                        ? {{16{ext[31]}}, ext[31:16]} : 32'h0;
                e.loc = base + dsp + (idx << ext[42:41]);
                e.prog = jp && !w;
            end
            default: {e.bad, e.prog} = {1'b1, !w && f[2:0] inside {[2:4]}};
        endcase
        if (f[5:3] == `MODE_POSTINC || f[5:3] == `MODE_PREDEC)
            am[k] = f[5:3] == `MODE_POSTINC ? base + st : base - st;
        notes.push_back(e);
        {ext_words, ea_field, op_size, op_write, op_jump, ea_req} = {ext, f, sz, w, jp, 1'b1};
        @(posedge mclk) #1;
        ea_req = 1'b0;
        for (k = 0; k < 60 && busy_ff !== 1'b0; k++)
            @(posedge mclk) #1;
        `CHK(busy_ff, 1'b0)
        if (f[5:3] inside {[2:4]})
            rd_chk(1'b1, f[2:0]);
    endtask
    always @(negedge mclk)
    begin
        if (done_ff === 1'b1)
        begin
            cur = notes.pop_front();
            `CHK(bad_ff, cur.bad)
            `CHK(loc_prog_ff, cur.prog)
            if (!cur.bad)
            begin
                `CHK(loc_kind_ff, cur.kind)
                `CHK(loc_num_ff, cur.num)
                `CHK(operand_locator_ff, cur.loc)
            end
        end
    end
    initial
    begin
        #300000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'hE5E35E18));
        foreach (dm[i]) dm[i] = 32'h0;
        foreach (am[i]) am[i] = 32'h0;
        repeat (6) @(posedge mclk);
        #1 rstn = 1'b1;
        `CHK(loc_kind_ff, LOC_NONE)
        for (r = 0; r < 16; r++)
        begin
            supervisor = r[3];
            wr_size = r[1:0];
            rd_chk(1'b0, r[2:0]);
            rd_chk(1'b1, r[2:0]);
            wreg(1'b0, r[2:0], $urandom);
            wreg(1'b1, r[2:0], $urandom);
        end
        op_fetch_req = 1'b1;
        @(posedge mclk) #1;
        op_fetch_req = 1'b0;
        `CHK({fetch_req_ff, fetch_prog_ff}, 2'h3)
        repeat (6) @(posedge mclk) #1;
        // carry out of bit 31 must vanish
        wreg(1'b1, 3'h2, 32'hFFFFFFFE);
        decode({`MODE_POSTINC, 3'h2}, `SZ_LONG, 1'b0, 1'b0, 48'h0);
        for (m = 0; m < 7; m++)
            for (z = 0; z < 3; z++)
                for (r = 0; r < 16; r++)
                begin
                    supervisor = r[3];
                    rv = {$urandom, $urandom};
                    j = rv[62];
                    if (!(m == 1 && z == 0))
                        decode({m[2:0], r[2:0]}, z[1:0], j ? 1'b0 : rv[63], j,
                            rv[47:0] & ~48'h010000000000);
                end
        for (z = 1; z < 4; z++)
            decode({`MODE_INDEX, 3'h4}, `SZ_LONG, 1'b0, 1'b1,
                {rv[47:41], 1'b1, 2'h0, z[1:0], 4'h0, rv[31:0]});
        decode({`MODE_SPECIAL, `SUB_IMM}, `SZ_WORD, 1'b0, 1'b0, 48'h0);
        // let the monitor take the last answer off the queue
        repeat (2) @(posedge mclk) #1;
        report_and_stop();
    end
endmodule // tb_top
